/* File: spcg_pkg.sv */
package spcg_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] SPCG_OFF_CTRL     = 4'h0;
   localparam logic [3:0] SPCG_OFF_DIV_LOW  = 4'h1;
   localparam logic [3:0] SPCG_OFF_DIV_HIGH = 4'h2;
   localparam logic [3:0] SPCG_OFF_STATUS   = 4'h3;
   // control register field positions
   localparam int SPCG_BIT_SYNC_MODE  = 0;
   localparam int SPCG_BIT_DOUBLE     = 1;
   localparam int SPCG_BIT_XCK_DIR    = 2;
   localparam int SPCG_BIT_POLARITY   = 3;
   localparam int SPCG_BIT_POWER_GATE = 4;
   localparam int SPCG_CTRL_W         = 5;
   // status register field positions
   localparam int SPCG_BIT_ST_MODE    = 0;
   localparam int SPCG_BIT_ST_XCK     = 2;
   localparam int SPCG_BIT_ST_ACTIVE  = 3;
   // values after reset: port held inactive by its power gate
   localparam logic [4:0]  SPCG_CTRL_RESET = 5'h10;
   localparam logic [11:0] SPCG_DIV_RESET  = 12'h000;
   // divide ratios and recovery state counts
   localparam int SPCG_DIV_NORMAL = 16;
   localparam int SPCG_DIV_DOUBLE = 8;
   localparam int SPCG_DIV_SYNC   = 2;
   localparam int SPCG_DIV_BITS   = 12;
   localparam int SPCG_STATE_W    = 5;
   // clock modes
   typedef enum logic [1:0] {
      SPCG_MODE_ASYNC_NORMAL,
      SPCG_MODE_ASYNC_DOUBLE,
      SPCG_MODE_SYNC_MASTER,
      SPCG_MODE_SYNC_SLAVE
   } spcg_mode_t;
endpackage

/* File: spcg_div_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spcg_div_if;
   import spcg_pkg::*;
   logic                    tick;
   logic                    clear;
   logic [SPCG_STATE_W-1:0] modulus;
   logic [SPCG_STATE_W-1:0] state;
   logic                    wrap;
   modport ctl (output tick, output clear, output modulus,
                input state, input wrap);
   modport cnt (input tick, input clear, input modulus,
                output state, output wrap);
endinterface
`default_nettype wire

/* File: spcg_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
module spcg_tick_div
   import spcg_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // counting port
   spcg_div_if.cnt   div
);
   logic [SPCG_STATE_W-1:0] state_reg;
   logic [SPCG_STATE_W-1:0] last_state;

   // last state before wrapping back to zero
   assign last_state = div.modulus - 5'h01;

   // state counter advanced once per base tick
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= 5'h00;
      else if (div.clear)
         state_reg <= 5'h00;
      else if (div.tick)
      begin
         if (state_reg >= last_state)
            state_reg <= 5'h00;
         else
            state_reg <= state_reg + 5'h01;
      end
   end

   // combinational wrap: caller registers it before any output
   assign div.state = state_reg;
   assign div.wrap  = div.tick && !div.clear && (state_reg >= last_state);
endmodule
`default_nettype wire

/* File: spcg_clock_gen.sv */
// Overview of operation
// - four clock modes; sync_mode_select picks asynchronous or synchronous
// - in sync mode xfer_clk_direction picks master (internal) or slave
// - transfer clock pin used only in synchronous mode, ignored otherwise
// - baud counter reloads at zero and on every low-byte write
// - one baud pulse per zero count: rate is clock over divisor plus one
// - baud divisor is twelve bits split over a high and low byte
// - transmit clock is baud pulse, or slave edges in slave mode, over 16, 8 or 2 by mode
// - receiver takes baud pulse, or slave edges in slave mode, directly and runs 16, 8 or 2 states
// - double_speed acts only in asynchronous mode, ignored when synchronous
// - double-speed receive uses 8 samples per bit instead of 16
// - slave clock is synchronised then edge detected, two clocks delay
// - pin is clock output as master, input as slave, same edges
// - sample on the transfer clock edge opposite the data change edge
// - polarity clear: change rising, sample falling; set: the reverse
// - port inactive while its power gate bit is set
`timescale 1ns/1ps
`default_nettype none
module spcg_clock_gen
   import spcg_pkg::*;
#(
   parameter int DIV_BITS = SPCG_DIV_BITS
)
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // register port
   input  wire logic [3:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output var  logic [7:0]               reg_rdata,
   // transfer clock pin
   input  wire logic                     xfer_clk_pin_in,
   output var  logic                     xfer_clk_pin_out,
   output var  logic                     xfer_clk_pin_oe_n,
   // base clocks to transmitter and receiver
   output var  logic                     tx_clk_en,
   output var  logic                     rx_base_clock,
   output var  logic [SPCG_STATE_W-1:0]  rx_sample_state,
   output var  logic                     rx_bit_done,
   // synchronous edge strobes
   output var  logic                     sync_change_en,
   output var  logic                     sync_sample_en,
   // mode seen by the rest of the port
   output var  logic [1:0]               clock_mode
);
   import spcg_pkg::*;

   logic [SPCG_CTRL_W-1:0] ctrl_reg;
   logic [DIV_BITS-1:0]    baud_divisor_reg;
   logic [DIV_BITS-1:0]    baud_cnt_reg;
   logic                   baud_tick;
   logic                   port_active;
   logic                   sync_mode_select;
   logic                   double_speed;
   logic                   xfer_clk_direction;
   logic                   sync_clk_polarity;
   spcg_mode_t             mode;
   logic                   wr_ctrl;
   logic                   wr_low;
   logic                   wr_high;
   logic                   xck_meta_reg;
   logic                   xck_sync_reg;
   logic                   xck_prev_reg;
   logic                   ext_rise;
   logic                   ext_fall;
   logic                   xck_out_reg;
   logic                   xck_out_next;
   logic                   int_rise;
   logic                   int_fall;
   logic                   clk_rise;
   logic                   clk_fall;
   logic                   tx_src_tick;
   logic                   rx_src_tick;
   logic [SPCG_STATE_W-1:0] tx_modulus;
   logic [SPCG_STATE_W-1:0] rx_modulus;

   spcg_div_if tx_div ();
   spcg_div_if rx_div ();

   // write decode
   assign wr_ctrl = reg_wr && (reg_addr == SPCG_OFF_CTRL);
   assign wr_low  = reg_wr && (reg_addr == SPCG_OFF_DIV_LOW);
   assign wr_high = reg_wr && (reg_addr == SPCG_OFF_DIV_HIGH);

   // control register fields
   assign sync_mode_select   = ctrl_reg[SPCG_BIT_SYNC_MODE];
   assign double_speed       = ctrl_reg[SPCG_BIT_DOUBLE];
   assign xfer_clk_direction = ctrl_reg[SPCG_BIT_XCK_DIR];
   assign sync_clk_polarity  = ctrl_reg[SPCG_BIT_POLARITY];
   assign port_active        = !ctrl_reg[SPCG_BIT_POWER_GATE];

   // control register; power gate set after reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= SPCG_CTRL_RESET;
      else if (wr_ctrl)
         ctrl_reg <= reg_wdata[SPCG_CTRL_W-1:0];
   end

   // divisor bytes; high nibble only, upper bits dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         baud_divisor_reg <= SPCG_DIV_RESET;
      else if (wr_low)
         baud_divisor_reg[7:0] <= reg_wdata;
      else if (wr_high)
         baud_divisor_reg[DIV_BITS-1:8] <= reg_wdata[DIV_BITS-9:0];
   end

   // mode selection from the three setting bits
   always_comb
   begin
      if (!sync_mode_select)
      begin
         if (double_speed)
            mode = SPCG_MODE_ASYNC_DOUBLE;
         else
            mode = SPCG_MODE_ASYNC_NORMAL;
      end
      else if (xfer_clk_direction)
         mode = SPCG_MODE_SYNC_MASTER;
      else
         mode = SPCG_MODE_SYNC_SLAVE;
   end

   // baud down-counter; the low byte write reloads with the new low byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         baud_cnt_reg <= SPCG_DIV_RESET;
      else if (!port_active)
         baud_cnt_reg <= baud_divisor_reg;
      else if (wr_low)
         baud_cnt_reg <= {baud_divisor_reg[DIV_BITS-1:8], reg_wdata};
      else if (baud_cnt_reg == '0)
         baud_cnt_reg <= baud_divisor_reg;
      else
         baud_cnt_reg <= baud_cnt_reg - DIV_BITS'(1);
   end

   // one pulse per zero count gives clk / (divisor + 1)
   assign baud_tick = port_active && !wr_low
                      && (baud_cnt_reg == '0);

   // external clock: two-stage synchroniser, then edge detector
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xck_meta_reg <= 1'b0;
         xck_sync_reg <= 1'b0;
         xck_prev_reg <= 1'b0;
      end
      else
      begin
         xck_meta_reg <= xfer_clk_pin_in;
         xck_sync_reg <= xck_meta_reg;
         xck_prev_reg <= xck_sync_reg;
      end
   end

   // edges seen only in slave mode; pin ignored otherwise
   assign ext_rise = (mode == SPCG_MODE_SYNC_SLAVE) && port_active
                     && xck_sync_reg && !xck_prev_reg;
   assign ext_fall = (mode == SPCG_MODE_SYNC_SLAVE) && port_active
                     && !xck_sync_reg && xck_prev_reg;

   // master clock level toggles on each baud pulse, idles at polarity
   always_comb
   begin
      if (mode != SPCG_MODE_SYNC_MASTER || !port_active)
         xck_out_next = sync_clk_polarity;
      else if (baud_tick)
         xck_out_next = !xck_out_reg;
      else
         xck_out_next = xck_out_reg;
   end

   // internal copy of the level for edge decode
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         xck_out_reg <= 1'b0;
      else
         xck_out_reg <= xck_out_next;
   end

   // internal edges: the register takes the new level next cycle
   assign int_rise = (mode == SPCG_MODE_SYNC_MASTER) && baud_tick
                     && !xck_out_reg;
   assign int_fall = (mode == SPCG_MODE_SYNC_MASTER) && baud_tick
                     && xck_out_reg;

   // same edge relation for master and slave roles
   assign clk_rise = int_rise || ext_rise;
   assign clk_fall = int_fall || ext_fall;

   // pin drive: output only as synchronous master
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xfer_clk_pin_out  <= 1'b0;
         xfer_clk_pin_oe_n <= 1'b1;
      end
      else
      begin
         xfer_clk_pin_out  <= xck_out_next; // pin edge beside its strobe
         xfer_clk_pin_oe_n <= !(mode == SPCG_MODE_SYNC_MASTER
                                && port_active);
      end
   end

   // change and sample strobes; polarity swaps the two edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_change_en <= 1'b0;
         sync_sample_en <= 1'b0;
      end
      else if (!sync_clk_polarity)
      begin
         sync_change_en <= clk_rise;
         sync_sample_en <= clk_fall;
      end
      else
      begin
         sync_change_en <= clk_fall;
         sync_sample_en <= clk_rise;
      end
   end

   // transmitter divide ratio by mode
   always_comb
   begin
      case (mode)
         SPCG_MODE_ASYNC_NORMAL:
            tx_modulus = 5'(SPCG_DIV_NORMAL);
         SPCG_MODE_ASYNC_DOUBLE:
            tx_modulus = 5'(SPCG_DIV_DOUBLE);
         SPCG_MODE_SYNC_MASTER:
            tx_modulus = 5'(SPCG_DIV_SYNC);
         default:
            tx_modulus = 5'(SPCG_DIV_SYNC);
      endcase
   end

   // receiver state count by mode; double speed halves the samples
   always_comb
   begin
      case (mode)
         SPCG_MODE_ASYNC_NORMAL:
            rx_modulus = 5'(SPCG_DIV_NORMAL);
         SPCG_MODE_ASYNC_DOUBLE:
            rx_modulus = 5'(SPCG_DIV_DOUBLE);
         default:
            rx_modulus = 5'(SPCG_DIV_SYNC);
      endcase
   end

   // slave mode: baud output is cut off, external edges only
   assign tx_src_tick = (mode == SPCG_MODE_SYNC_SLAVE)
                        ? (ext_rise || ext_fall) : baud_tick;
   assign rx_src_tick = tx_src_tick;

   // transmit divider
   assign tx_div.tick    = tx_src_tick;
   assign tx_div.clear   = wr_ctrl || !port_active;
   assign tx_div.modulus = tx_modulus;

   spcg_tick_div u_tx_div (
      .clk   (clk),
      .rst_n (rst_n),
      .div   (tx_div.cnt)
   );

   // receive recovery state counter
   assign rx_div.tick    = rx_src_tick;
   assign rx_div.clear   = wr_ctrl || !port_active;
   assign rx_div.modulus = rx_modulus;

   spcg_tick_div u_rx_div (
      .clk   (clk),
      .rst_n (rst_n),
      .div   (rx_div.cnt)
   );

   // registered base clocks; slight latency traded for clean outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_clk_en       <= 1'b0;
         rx_base_clock   <= 1'b0;
         rx_bit_done     <= 1'b0;
         rx_sample_state <= 5'h00;
      end
      else
      begin
         tx_clk_en       <= tx_div.wrap;
         rx_base_clock   <= rx_src_tick;
         rx_bit_done     <= rx_div.wrap;
         rx_sample_state <= rx_div.state;
      end
   end

   // current mode for the rest of the port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clock_mode <= 2'h0;
      else
         clock_mode <= mode;
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (!reg_rd)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_addr)
            SPCG_OFF_CTRL:
               reg_rdata <= {3'h0, ctrl_reg};
            SPCG_OFF_DIV_LOW:
               reg_rdata <= baud_divisor_reg[7:0];
            SPCG_OFF_DIV_HIGH:
               reg_rdata <= {4'h0, baud_divisor_reg[DIV_BITS-1:8]};
            SPCG_OFF_STATUS:
               reg_rdata <= {4'h0, port_active, xck_sync_reg, mode};
            default:
               reg_rdata <= 8'h00; // unmapped reads as zero
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: spcg_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module spcg_remote
#(
   parameter int HALF = 3
)
(
   // bench control
   input  wire logic clk,
   input  wire logic go,
   input  wire logic idle_lvl,
   // transfer clock line
   output var  logic pin
);
   int   left = 0;
   int   t    = 0;
   logic p    = 1'b0;
   assign pin = p;
   // clock stands at its idle level between frames of 16 edges
   always @(posedge clk)
   begin
      if (left == 0)
      begin
         p <= idle_lvl;
         left <= go ? 16 : 0;
         t <= 0;
      end
      else if (t == HALF - 1)
      begin
         p <= ~p; // half period of 3 clocks keeps it under clk/4
         left <= left - 1;
         t <= 0;
      end
      else
         t <= t + 1;
   end
endmodule
`default_nettype wire

/* File: spcg_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module spcg_sva
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // watched ports
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       xfer_clk_pin_in,
   input wire logic       xfer_clk_pin_out,
   input wire logic       xfer_clk_pin_oe_n,
   input wire logic       tx_clk_en,
   input wire logic       rx_base_clock,
   input wire logic [4:0] rx_sample_state,
   input wire logic       sync_change_en,
   input wire logic       sync_sample_en,
   input wire logic [1:0] clock_mode
);
   logic [1:0] m1_reg;
   logic [1:0] m2_reg;
   logic       steady;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // mode history: outputs may lag a mode change by a cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         m1_reg <= 2'h0;
         m2_reg <= 2'h0;
      end
      else
      begin
         m1_reg <= clock_mode;
         m2_reg <= m1_reg;
      end
   end
   assign steady = (clock_mode == m1_reg) && (m1_reg == m2_reg);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   property p_async_quiet;
      steady && !clock_mode[1] |-> !sync_change_en && !sync_sample_en;
   endproperty
   property p_edges_apart;
      !(sync_change_en && sync_sample_en);
   endproperty
   property p_drive_master;
      !xfer_clk_pin_oe_n |-> clock_mode == 2'h2 || m1_reg == 2'h2;
   endproperty
   property p_sync_states;
      steady && clock_mode[1] |-> rx_sample_state < 5'h02;
   endproperty
   property p_slave_lat;
      steady && clock_mode == 2'h3 && $changed(xfer_clk_pin_in)
         |-> ##[2:4] (sync_change_en || sync_sample_en);
   endproperty
   property p_slave_quiet;
      (steady && clock_mode == 2'h3 && $stable(xfer_clk_pin_in))[*5]
         |-> !rx_base_clock && !tx_clk_en;
   endproperty
   property p_master_pin;
      steady && clock_mode == 2'h2 && (sync_change_en || sync_sample_en)
         |-> $changed(xfer_clk_pin_out);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   a_async_quiet: assert property (p_async_quiet)
      else $error("sync strobe while asynchronous");
   a_edges_apart: assert property (p_edges_apart)
      else $error("change and sample on one edge");
   a_drive_master: assert property (p_drive_master)
      else $error("pin driven outside master mode");
   a_sync_states: assert property (p_sync_states)
      else $error("sync recovery state out of range");
   a_slave_lat: assert property (p_slave_lat)
      else $error("slave edge not seen in time");
   a_slave_quiet: assert property (p_slave_quiet)
      else $error("slave clocked without an edge");
   a_master_pin: assert property (p_master_pin)
      else $error("master strobe without pin edge");
   c_tx: cover property (tx_clk_en);
   c_slave: cover property (clock_mode == 2'h3 && sync_sample_en);
   c_master: cover property (clock_mode == 2'h2 && sync_change_en);
endmodule
bind spcg_clock_gen spcg_sva u_sva (
   .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .xfer_clk_pin_in(xfer_clk_pin_in), .xfer_clk_pin_out(xfer_clk_pin_out),
   .xfer_clk_pin_oe_n(xfer_clk_pin_oe_n), .tx_clk_en(tx_clk_en),
   .rx_base_clock(rx_base_clock), .rx_sample_state(rx_sample_state),
   .sync_change_en(sync_change_en), .sync_sample_en(sync_sample_en),
   .clock_mode(clock_mode)
);
`default_nettype wire

/* File: spcg_clock_gen_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spcg_clock_gen_test;
   import spcg_pkg::*;
   // design ports
   logic                    clk       = 1'b0;
   logic                    rst_n     = 1'b0;
   logic [3:0]              reg_addr  = 4'h0;
   logic [7:0]              reg_wdata = 8'h00;
   logic                    reg_wr    = 1'b0;
   logic                    reg_rd    = 1'b0;
   logic [7:0]              reg_rdata;
   logic                    line;
   logic                    rpin;
   logic                    pin_out;
   logic                    oe_n;
   logic                    tx_en;
   logic                    rx_clk;
   logic [SPCG_STATE_W-1:0] rx_state;
   logic                    chg;
   logic                    smp;
   logic                    bdone;
   logic [1:0]              mode;
   // bench state
   logic                    go          = 1'b0;
   logic                    pol         = 1'b0;
   bit                      mon         = 1'b0;
   int                      cnt[7];
   int                      first;
   int                      fail_count  = 0;
   int                      check_count = 0;
   int                      seed        = 32'haf92;
   // 100 MHz system clock
   always #5 clk = ~clk;
   // wire level: design when it drives, else the remote end
   assign line = oe_n ? rpin : pin_out;
   spcg_clock_gen u_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .xfer_clk_pin_in(line),
      .xfer_clk_pin_out(pin_out), .xfer_clk_pin_oe_n(oe_n),
      .tx_clk_en(tx_en), .rx_base_clock(rx_clk),
      .rx_sample_state(rx_state), .rx_bit_done(bdone),
      .sync_change_en(chg), .sync_sample_en(smp), .clock_mode(mode)
   );
   spcg_remote u_remote (.clk(clk), .go(go), .idle_lvl(pol), .pin(rpin));
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata === e, "read data");
   endtask
   // counts cycles, pulses and top recovery state until limit, or until tx pulse when stop is set
   task automatic meas(input int lim, input bit stop);
      cnt = '{default: 0};
      first = 0;
      do
      begin
         @(posedge clk);
         #1;
         cnt[0]++;
         cnt[1] += rx_clk;
         cnt[2] += tx_en;
         cnt[3] += chg;
         cnt[4] += smp;
         cnt[6] += bdone;
         if (rx_state > cnt[5]) cnt[5] = rx_state;
         if (first == 0) first = smp ? 2 : chg;
         if (mon && mode === 2'h2)
         begin
            if (chg === 1'b1) chk(pin_out === ~pol, "change level");
            if (smp === 1'b1) chk(pin_out === pol, "sample level");
            chk(oe_n === 1'b0, "pin not driven");
         end
      end while (!(stop && tx_en === 1'b1) && cnt[0] < lim);
   endtask
   // a frame from the remote end; settle first so stray edges pass
   task automatic frame;
      repeat (6) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      meas(120, 1'b0);
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // reset, mode table with random divisors and a fixed 12'h101 last, slave frames, async frame
   initial
   begin
      static logic [4:0] ctab[5] = '{5'h00, 5'h02, 5'h05, 5'h0F, 5'h07};
      static int         ntab[5] = '{16, 8, 2, 2, 2};
      static logic [1:0] mtab[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
      logic [11:0] d;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(SPCG_OFF_CTRL, {3'h0, SPCG_CTRL_RESET});
      rd(SPCG_OFF_STATUS, 8'h00);
      rd(4'hF, 8'h00);
      wr(SPCG_OFF_DIV_LOW, 8'h01);
      meas(40, 1'b0);
      chk(cnt[1] == 0 && cnt[2] == 0, "gated port ran");
      for (int i = 0; i < 5; i++)
      begin
         d = (i == 4) ? 12'h101 : 12'($random(seed) & 7);
         pol <= ctab[i][3];
         wr(SPCG_OFF_DIV_HIGH, {4'h0, d[11:8]});
         wr(SPCG_OFF_CTRL, {3'h0, ctab[i]});
         wr(SPCG_OFF_DIV_LOW, d[7:0]);
         meas(9000, 1'b1);
         mon = 1'b1;
         meas(9000, 1'b1);
         mon = 1'b0;
         chk(cnt[1] == ntab[i], "baud pulses per tx");
         chk(cnt[0] == ntab[i] * (d + 1), "baud period");
         chk(cnt[5] == ntab[i] - 1, "recovery states");
         chk(cnt[6] == 1, "bit done per tx period");
         chk(mode === mtab[i], "clock mode");
      end
      for (int p = 0; p < 2; p++)
      begin
         pol <= p[0];
         wr(SPCG_OFF_CTRL, {4'h0, p[0], 3'h1});
         frame();
         chk(cnt[1] == 16 && cnt[2] == 8, "slave clocks");
         chk(cnt[6] == 8, "slave bit done");
         chk(cnt[3] == 8 && cnt[4] == 8, "slave strobes");
         chk(first == 1, "first strobe");
         chk(mode === 2'h3, "slave mode");
      end
      wr(SPCG_OFF_CTRL, 8'h00);
      frame();
      chk(cnt[3] == 0 && cnt[4] == 0, "pin used when async");
      give_verdict();
   end
   // watchdog in case a wait never ends
   initial
   begin
      #200000;
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
